// File: hdl/pwc_params.svh
// Purpose: offsets, field positions and reset values of the pwm channel
// Assumes: register index times four gives the axi byte address
// Notes: definitions only
`ifndef PWC_PARAMS_SVH
`define PWC_PARAMS_SVH
// register indexes
`define PWC_IDX_PERIOD  30'h0306000
`define PWC_IDX_PULSE   30'h0306002
`define PWC_IDX_COUNTER 30'h0306004
`define PWC_IDX_SCR     30'h0306006
`define PWC_IDX_IRQ_ST  30'h03060F0
`define PWC_IDX_IRQ_MSK 30'h03060F1
// status/control field positions
`define PWC_POS_PIN     15
`define PWC_POS_DIR     14
`define PWC_POS_FRZ     13
`define PWC_POS_TRANSPARENT_BUFFER_BIT    12
`define PWC_POS_INV     11
`define PWC_POS_EN      10
`define PWC_CP_MSB      7
// interrupt status bit positions
`define PWC_IRQ_START   0
`define PWC_IRQ_END     1
// reset values
`define PWC_RST_CP      8'h00
`define PWC_RST_WORD16  16'h0000
// axi responses
`define PWC_RESP_OKAY   2'h0
`define PWC_RESP_SLVERR 2'h2
`endif

// File: hdl/pwc_pkg.sv
// Purpose: types shared by the pwm channel
// Assumes: nothing
// Notes: used with full scope, never imported
package pwc_pkg;
	// software control bits of the channel
	typedef struct packed {
		logic       dir;
		logic       frz_en;
		logic       transp;
		logic       inv;
		logic       en;
		logic [7:0] cp;
	} pwc_ctrl_type;
	// channel events
	typedef struct packed {
		logic pulse_end;
		logic period_start;
	} pwc_evt_type;
endpackage : pwc_pkg

// File: hdl/pwc_channel.sv
// Purpose: one pwm channel with pin i/o mode, axi4-lite register slave
// Assumes: single clock aclk, synchronous active-low reset
// Notes: registers sit at byte address four times their index
`timescale 1ns/1ps
`include "pwc_params.svh"

module pwc_channel #(
	parameter int AW = 32
) (
	// clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// axi4-lite write address and data
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	// axi4-lite write response
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	// axi4-lite read
	input  wire logic [AW-1:0] araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready,
	// module freeze and pin
	input  wire logic          freeze_in,
	input  wire logic          pin_i,
	output logic               pin_o,
	output logic               pin_oe_n,
	// interrupt
	output logic               irq
);
	pwc_pkg::pwc_ctrl_type ctrl_q, ctrl_d;
	pwc_pkg::pwc_evt_type  evt, st_q, st_d, msk_q, msk_d;
	logic [15:0]   period_q, period_d, pul_a_q, pul_a_d, pul_b_q, pul_b_d;
	logic [15:0]   cnt_q, cnt_d, pend_q, pend_d, wval;
	logic [7:0]    pre_q, pre_d;
	logic          pend_v_q, pend_v_d, out_q, out_d, pin_q, pin_d;
	logic          po_q, po_d, oen_q, oen_d, frozen, tick, wrap, wr_go;
	logic [2:0]    sync_q;
	logic          aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [AW-1:0] awa_q, awa_d;
	logic [31:0]   wd_q, wd_d, rd_q, rd_d;
	logic [3:0]    ws_q, ws_d;
	logic [1:0]    br_q, br_d, rr_q, rr_d;
	logic          hit_per, hit_pul, hit_cnt, hit_scr, hit_st, hit_msk;

	// handshake outputs and registered data
	assign awready  = !aw_q;
	assign wready   = !w_q;
	assign bvalid   = bv_q;
	assign bresp    = br_q;
	assign arready  = !rv_q;
	assign rvalid   = rv_q;
	assign rdata    = rd_q;
	assign rresp    = rr_q;
	assign pin_o    = po_q;
	assign pin_oe_n = oen_q;
	assign irq      = |(st_q & msk_q);

	// write decode and byte-lane merge onto the addressed register
	assign wr_go   = aw_q && w_q && !bv_q;
	assign hit_per = awa_q == AW'({`PWC_IDX_PERIOD, 2'b00});
	assign hit_pul = awa_q == AW'({`PWC_IDX_PULSE, 2'b00});
	assign hit_cnt = awa_q == AW'({`PWC_IDX_COUNTER, 2'b00});
	assign hit_scr = awa_q == AW'({`PWC_IDX_SCR, 2'b00});
	assign hit_st  = awa_q == AW'({`PWC_IDX_IRQ_ST, 2'b00});
	assign hit_msk = awa_q == AW'({`PWC_IDX_IRQ_MSK, 2'b00});

	// merged 16-bit write value for the addressed register
	always_comb begin
		logic [15:0] old;
		old = 16'h0000;
		if (hit_per)
			old = period_q;
		else if (hit_pul)
			old = pul_a_q;
		else if (hit_cnt)
			old = cnt_q;
		wval[7:0]  = ws_q[0] ? wd_q[7:0] : old[7:0];
		wval[15:8] = ws_q[1] ? wd_q[15:8] : old[15:8];
	end

	// axi write channel next state
	always_comb begin
		aw_d  = aw_q;
		awa_d = awa_q;
		w_d   = w_q;
		wd_d  = wd_q;
		ws_d  = ws_q;
		bv_d  = bv_q;
		br_d  = br_q;
		if (awvalid && !aw_q) begin
			aw_d  = 1'b1;
			awa_d = awaddr;
		end
		if (wvalid && !w_q) begin
			w_d  = 1'b1;
			wd_d = wdata;
			ws_d = wstrb;
		end
		if (wr_go) begin
			aw_d = 1'b0;
			w_d  = 1'b0;
			bv_d = 1'b1;
			br_d = (hit_per || hit_pul || hit_cnt || hit_scr || hit_st || hit_msk)
				? `PWC_RESP_OKAY : `PWC_RESP_SLVERR;
		end else if (bv_q && bready) begin
			bv_d = 1'b0;
		end
	end

	// axi read channel next state
	always_comb begin
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		if (arvalid && !rv_q) begin
			rv_d = 1'b1;
			rr_d = `PWC_RESP_OKAY;
			rd_d = 32'h0000_0000;
			if (araddr == AW'({`PWC_IDX_PERIOD, 2'b00}))
				rd_d[15:0] = period_q;
			else if (araddr == AW'({`PWC_IDX_PULSE, 2'b00}))
				rd_d[15:0] = pul_a_q;
			else if (araddr == AW'({`PWC_IDX_COUNTER, 2'b00}))
				rd_d[15:0] = cnt_q;
			else if (araddr == AW'({`PWC_IDX_SCR, 2'b00}))
				rd_d[15:0] = {pin_q, ctrl_q.dir, ctrl_q.frz_en, ctrl_q.transp,
					ctrl_q.inv, ctrl_q.en, 2'b00, ctrl_q.cp};
			else if (araddr == AW'({`PWC_IDX_IRQ_ST, 2'b00}))
				rd_d[1:0] = st_q;
			else if (araddr == AW'({`PWC_IDX_IRQ_MSK, 2'b00}))
				rd_d[1:0] = msk_q;
			else
				rr_d = `PWC_RESP_SLVERR;
		end else if (rv_q && rready) begin
			rv_d = 1'b0;
		end
	end

	// prescaler tick and period wrap
	assign frozen = ctrl_q.frz_en && freeze_in;
	assign tick   = ctrl_q.en && !frozen && pre_q == 8'hFF;
	assign wrap   = tick && ({1'b0, cnt_q} + 17'h00001 >= {1'b0, period_q});

	// pwm core, control word and interrupt flags next state
	always_comb begin
		ctrl_d   = ctrl_q;
		period_d = period_q;
		pul_a_d  = pul_a_q;
		pul_b_d  = pul_b_q;
		cnt_d    = cnt_q;
		pre_d    = pre_q;
		pend_d   = pend_q;
		pend_v_d = pend_v_q;
		out_d    = out_q;
		evt      = '0;
		msk_d    = msk_q;
		// prescaler and counter run only when enabled and not frozen
		if (ctrl_q.en && !frozen) begin
			pre_d = tick ? ctrl_q.cp : 8'(pre_q + 8'h01);
			if (wrap) begin
				cnt_d            = pend_v_q ? pend_q : 16'h0000;
				pend_v_d         = 1'b0;
				pul_b_d          = pul_a_q;
				out_d            = pul_a_q != 16'h0000;
				evt.period_start = 1'b1;
			end else if (tick) begin
				cnt_d = 16'(cnt_q + 16'h0001);
				if (16'(cnt_q + 16'h0001) == pul_b_q && out_q) begin
					out_d         = 1'b0;
					evt.pulse_end = 1'b1;
				end
			end
		end else if (!ctrl_q.en) begin
			out_d = 1'b0;
		end
		// software writes win over the counter in the same cycle
		if (wr_go && hit_per)
			period_d = wval;
		if (wr_go && hit_pul) begin
			pul_a_d = wval;
			if (ctrl_q.transp)
				pul_b_d = wval;
		end
		if (wr_go && hit_cnt) begin
			period_d = wval;
			if (ctrl_q.transp) begin
				cnt_d    = wval;
				pend_v_d = 1'b0;
			end else begin
				pend_d   = wval;
				pend_v_d = 1'b1;
			end
		end
		if (wr_go && hit_scr) begin
			if (ws_q[1]) begin
				ctrl_d.dir    = wd_q[`PWC_POS_DIR];
				ctrl_d.frz_en = wd_q[`PWC_POS_FRZ];
				ctrl_d.transp = wd_q[`PWC_POS_TRANSPARENT_BUFFER_BIT];
				ctrl_d.inv    = wd_q[`PWC_POS_INV];
				ctrl_d.en     = wd_q[`PWC_POS_EN];
			end
			if (ws_q[0])
				ctrl_d.cp = wd_q[`PWC_CP_MSB:0];
		end
		if (wr_go && hit_msk && ws_q[0])
			msk_d = wd_q[1:0];
		// sticky flags, write one clears, a new event wins
		st_d = st_q;
		if (wr_go && hit_st && ws_q[0])
			st_d = st_q & ~wd_q[1:0];
		st_d = st_d | evt;
	end

	// pin drive from output flop, polarity and direction
	always_comb begin
		pin_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : pin_q;
		po_d  = po_q;
		oen_d = 1'b1;
		if (ctrl_q.en) begin
			oen_d = 1'b0;
			if (!frozen)
				po_d = out_q ^ ctrl_q.inv;
		end else if (ctrl_q.dir) begin
			oen_d = 1'b0;
			po_d  = ctrl_q.inv;
		end
	end

	// all registers
	always_ff @(posedge aclk) begin
		sync_q <= {sync_q[1:0], pin_i};
		if (!aresetn) begin
			aw_q     <= 1'b0;
			awa_q    <= '0;
			w_q      <= 1'b0;
			wd_q     <= 32'h0000_0000;
			ws_q     <= 4'h0;
			bv_q     <= 1'b0;
			br_q     <= `PWC_RESP_OKAY;
			rv_q     <= 1'b0;
			rd_q     <= 32'h0000_0000;
			rr_q     <= `PWC_RESP_OKAY;
			ctrl_q   <= '{cp: `PWC_RST_CP, default: 1'b0};
			period_q <= `PWC_RST_WORD16;
			pul_a_q  <= `PWC_RST_WORD16;
			pul_b_q  <= `PWC_RST_WORD16;
			cnt_q    <= `PWC_RST_WORD16;
			pend_q   <= `PWC_RST_WORD16;
			pend_v_q <= 1'b0;
			pre_q    <= `PWC_RST_CP;
			out_q    <= 1'b0;
			pin_q    <= 1'b0;
			po_q     <= 1'b0;
			oen_q    <= 1'b1;
			st_q     <= '0;
			msk_q    <= '0;
		end else begin
			aw_q     <= aw_d;
			awa_q    <= awa_d;
			w_q      <= w_d;
			wd_q     <= wd_d;
			ws_q     <= ws_d;
			bv_q     <= bv_d;
			br_q     <= br_d;
			rv_q     <= rv_d;
			rd_q     <= rd_d;
			rr_q     <= rr_d;
			ctrl_q   <= ctrl_d;
			period_q <= period_d;
			pul_a_q  <= pul_a_d;
			pul_b_q  <= pul_b_d;
			cnt_q    <= cnt_d;
			pend_q   <= pend_d;
			pend_v_q <= pend_v_d;
			pre_q    <= pre_d;
			out_q    <= out_d;
			pin_q    <= pin_d;
			po_q     <= po_d;
			oen_q    <= oen_d;
			st_q     <= st_d;
			msk_q    <= msk_d;
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	pin_filter_a: assert property (sync_q[1] == sync_q[2] |=> pin_q == $past(sync_q[2]))
		else $error("pin status does not follow settled pin");
	dir_input_a: assert property (!ctrl_q.en && !ctrl_q.dir |=> pin_oe_n)
		else $error("pin driven while in input mode");
	freeze_hold_a: assert property (frozen && !wr_go |=> $stable(cnt_q) && $stable(pre_q))
		else $error("counter moved while frozen");
	transp_pulse_a: assert property (wr_go && hit_pul && ctrl_q.transp |=> pul_b_q == pul_a_q)
		else $error("transparent pulse write not applied");
	polarity_a: assert property (ctrl_q.en && !frozen |=> pin_o == ($past(out_q) ^ $past(ctrl_q.inv)))
		else $error("pin level disagrees with flop and polarity");
	enable_out_a: assert property (ctrl_q.en |=> !pin_oe_n)
		else $error("pin not output while enabled");
	prescale_load_a: assert property (tick |=> pre_q == $past(ctrl_q.cp))
		else $error("prescaler not reloaded from modulus");
	period_start_a: assert property (evt.period_start |=> out_q == (pul_b_q != 16'h0000) && st_q[0])
		else $error("period start edge or flag missing");
	hold_level_a: assert property (!ctrl_q.en && ctrl_q.dir |=> pin_o == $past(ctrl_q.inv) && !pin_oe_n)
		else $error("disabled output level wrong");
	counter_period_a: assert property (wr_go && hit_cnt |=> period_q == $past(wval))
		else $error("counter write did not reach period");

	start_seen_c: cover property (evt.period_start ##[1:300] evt.pulse_end);
	irq_seen_c: cover property (irq);
	frozen_seen_c: cover property (frozen && ctrl_q.en);
endmodule : pwc_channel

// File: tb/pwc_load.sv
// Purpose: load on the channel pin, echoes driven level or own level
// Assumes: no pull resistor, released pin follows the load's level
// Notes: load level comes from the bench
`timescale 1ns/1ps
module pwc_load (
	// pin from the channel
	input  wire logic pin_o,
	input  wire logic pin_oe_n,
	// level forced by the load
	input  wire logic ext_lvl,
	// level seen on the wire
	output logic      pin_i
);
	// wire level from both parties
	assign pin_i = pin_oe_n ? ext_lvl : pin_o;
endmodule : pwc_load

// File: tb/tb.sv
// Purpose: self-checking bench of the pwm channel
// Assumes: 25 MHz aclk, axi4-lite master by tasks
// Notes: pin mode table in rows, pwm cases by hand
`timescale 1ns/1ps
`include "pwc_params.svh"
module tb;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, freeze_in, pin_i, pin_o, pin_oe_n;
	logic        irq, ext_lvl, f;
	logic [31:0] awaddr, wdata, araddr, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rr, br;
	int          mismatches, n_compared, cyc, hi, k;
	logic [17:0] rows [6] = '{18'h00002, 18'h10000, 18'h12001, 18'h02002, 18'h01000, 18'h13001};
	localparam logic [31:0] A_PER = {`PWC_IDX_PERIOD, 2'b00};
	localparam logic [31:0] A_PUL = {`PWC_IDX_PULSE, 2'b00};
	localparam logic [31:0] A_CNT = {`PWC_IDX_COUNTER, 2'b00};
	localparam logic [31:0] A_SCR = {`PWC_IDX_SCR, 2'b00};
	localparam logic [31:0] A_IST = {`PWC_IDX_IRQ_ST, 2'b00};
	localparam logic [31:0] A_IMS = {`PWC_IDX_IRQ_MSK, 2'b00};

	pwc_channel DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.freeze_in(freeze_in), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .irq(irq));
	pwc_load u_load (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl), .pin_i(pin_i));

	// clock source
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// write: address and data together, each dropped when taken
	task automatic axw(input logic [31:0] a, input logic [31:0] d);
		logic da, dw, ta, tw, bv;
		da = 0;
		dw = 0;
		bv = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			da |= ta;
			dw |= tw;
		end
		while (!bv) begin
			@(negedge aclk);
			bv = bvalid;
			br = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask : axw

	// read: result left in rd and rr
	task automatic axr(input logic [31:0] a);
		logic rv, ta;
		rv = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rv) begin
			@(negedge aclk);
			rv = rvalid;
			rd = rdata;
			rr = rresp;
			ta = arvalid && arready;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : axr

	task automatic cnt_hi(input int n);
		hi = 0;
		repeat (n) begin
			@(negedge aclk);
			if (pin_o === 1'b1) hi++;
		end
	endtask : cnt_hi

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, freeze_in, ext_lvl} = '0;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(A_SCR);
		chk(rd & 32'h7F00, 32'h0);
		chk(rr, `PWC_RESP_OKAY);
		chk(pin_oe_n, 1'b1);
		axr(32'h0);
		chk({rr, rd[29:0]}, 32'h80000000);
		$display("test reset done");
		// pin mode table
		for (k = 0; k < 6; k++) begin
			axw(A_SCR, rows[k][17:2]);
			repeat (3) @(posedge aclk);
			chk(pin_oe_n, rows[k][1]);
			if (!rows[k][1]) chk(pin_o, rows[k][0]);
		end
		// last row drives the pin high while the load sits low
		repeat (3) @(posedge aclk);
		axr(A_SCR);
		chk(rd & 32'h8000, 32'h8000);
		$display("test pin modes done");
		axw(A_SCR, 32'h0);
		ext_lvl <= 1'b1;
		repeat (5) @(posedge aclk);
		axw(A_SCR, 32'h0);
		axr(A_SCR);
		chk(rd & 32'h8000, 32'h8000);
		ext_lvl <= 1'b0;
		repeat (5) @(posedge aclk);
		axw(A_SCR, 32'h8000);
		axr(A_SCR);
		chk(rd & 32'h8000, 32'h0);
		axw(A_SCR, 32'h3FF);
		axr(A_SCR);
		chk(rd & 32'hFFFF7FFF, 32'hFF);
		chk(br, `PWC_RESP_OKAY);
		// low lane only: control bits keep their value
		wstrb <= 4'h1;
		axw(A_SCR, 32'h7C12);
		wstrb <= 4'hF;
		axr(A_SCR);
		chk(rd & 32'h7FFF, 32'h12);
		axw(32'h4, 32'h0);
		chk(br, `PWC_RESP_SLVERR);
		$display("test status word done");
		axw(A_PER, 32'd10);
		axw(A_PUL, 32'd3);
		axw(A_SCR, 32'h4FF);
		// prescaler resumes from its held value, up to 256 cycles to first tick
		repeat (300) @(posedge aclk);
		cnt_hi(100);
		chk(32'(hi), 32'd30);
		axw(A_SCR, 32'hCFF);
		repeat (20) @(posedge aclk);
		cnt_hi(100);
		chk(32'(hi), 32'd70);
		axw(A_SCR, 32'h4FE);
		repeat (40) @(posedge aclk);
		cnt_hi(200);
		chk(32'(hi), 32'd60);
		$display("test pwm done");
		axr(A_IST);
		chk(rd & 32'h3, 32'h3);
		chk(irq, 1'b0);
		axw(A_IMS, 32'h1);
		chk(irq, 1'b1);
		axw(A_SCR, 32'h0);
		axw(A_IST, 32'h3);
		axr(A_IST);
		chk(rd, 32'h0);
		chk(irq, 1'b0);
		$display("test interrupt done");
		axw(A_SCR, 32'h24FF);
		freeze_in <= 1'b1;
		repeat (5) @(posedge aclk);
		f = pin_o;
		cnt_hi(40);
		chk(32'(hi), f ? 32'd40 : 32'd0);
		axw(A_SCR, 32'h4FF);
		repeat (20) @(posedge aclk);
		cnt_hi(100);
		chk(32'(hi), 32'd30);
		freeze_in <= 1'b0;
		axw(A_CNT, 32'd7);
		axr(A_PER);
		chk(rd, 32'd7);
		repeat (20) @(posedge aclk);
		cnt_hi(70);
		chk(32'(hi), 32'd30);
		$display("test freeze and counter done");
		// transparent counter and pulse writes, then a deferred one
		axw(A_SCR, 32'h1000);
		axw(A_CNT, 32'h1234);
		axr(A_CNT);
		chk(rd, 32'h1234);
		axw(A_PUL, 32'h2);
		axw(A_SCR, 32'h0);
		axw(A_CNT, 32'h55);
		axr(A_CNT);
		chk(rd, 32'h1234);
		axr(A_PER);
		chk(rd, 32'h55);
		$display("test transparent done");
		// reset in mid-run with control bits set and pin driven
		axw(A_SCR, 32'h5000);
		repeat (3) @(posedge aclk);
		chk(pin_oe_n, 1'b0);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(A_SCR);
		chk(rd & 32'h7F00, 32'h0);
		chk(pin_oe_n, 1'b1);
		axr(A_IST);
		chk(rd, 32'h0);
		$display("test reset again done");
		print_verdict();
	end
endmodule : tb
